//--- bpv_video_port.v
// Streaming video port of the Bayer processing pipeline
`timescale 1ns/1ps
`include "bpv_consts.vh"

////////////////////////////////////////////////////////////////////////
module bpv_video_port (
  // Clock, reset, enable, clear
  input wire clk_sys_in,
  input wire reset_in,
  input wire ce_in,
  input wire sclr_in,
  // Input stream
  input wire [`BPV_INPUT_SAMPLE_WIDTH-1:0] video_data_in,
  input wire hblank_in,
  input wire vblank_in,
  input wire active_video_in,
  output reg in_ready_out,
  // Output stream
  output reg [`BPV_OUT_BUS_WIDTH-1:0] video_data_out,
  output reg hblank_out,
  output reg vblank_out,
  output reg active_video_out,
  output reg stream_valid_out,
  input wire sink_ready_in,
  // no bus slave ports
  // Programmable values as ports
  input wire [1:0] control_in,
  input wire [1:0] bayer_phase_in,
  input wire [`BPV_INPUT_SAMPLE_WIDTH-1:0] black_level_in,
  input wire [`BPV_STAT_WIDTH-1:0] irq_mask_in,
  input wire [`BPV_STAT_WIDTH-1:0] status_clear_in,
  output reg [`BPV_STAT_WIDTH-1:0] status_out,
  output reg irq_out
);

  localparam IW = `BPV_INPUT_SAMPLE_WIDTH;
  localparam OW = `BPV_OUTPUT_COMPONENT_WIDTH;
  localparam BW = `BPV_OUT_BUS_WIDTH;
  localparam DS = `BPV_DELAY_STAGES;

  ////////////////////////////////////////////////////////////////////////
  // Pipeline advance

  // advance only with enable and room downstream
  wire adv;
  assign adv = ce_in & in_ready_out;

  // fixed defaults until loaded
  // Working registers used by the datapath
  reg [1:0] work_ctrl;
  reg [1:0] work_phase;
  reg [IW-1:0] work_black;

  // Stage 1 sample and frame edge tracking
  reg [IW-1:0] s1_data;
  reg vblank_prev;
  reg col_odd;
  reg row_odd;
  reg av_prev;
  wire frame_end;
  wire line_end;
  assign frame_end = vblank_in & ~vblank_prev;
  assign line_end = av_prev & ~active_video_in;

  ////////////////////////////////////////////////////////////////////////
  // Shadow load at frame end

  // copy user values only at frame end
  // and only once the host marks writes done
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      work_ctrl <= `BPV_CTRL_RESET;
      work_phase <= `BPV_PHASE_RESET;
      work_black <= `BPV_BLACK_RESET;
    end else if (adv && frame_end &&
                 control_in[`BPV_CTRL_DONE_BIT]) begin
      work_ctrl <= control_in;
      work_phase <= bayer_phase_in;
      work_black <= black_level_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bayer site tracking

  // line blanking and valid mark scan position
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      vblank_prev <= 1'b0;
      av_prev <= 1'b0;
      col_odd <= 1'b0;
      row_odd <= 1'b0;
    end else if (sclr_in) begin
      vblank_prev <= 1'b0;
      av_prev <= 1'b0;
      col_odd <= 1'b0;
      row_odd <= 1'b0;
    end else if (adv) begin
      vblank_prev <= vblank_in;
      av_prev <= active_video_in;
      if (vblank_in) begin
        row_odd <= 1'b0;
        col_odd <= 1'b0;
      end else if (line_end || hblank_in) begin
        col_odd <= 1'b0;
        if (line_end) begin
          row_odd <= ~row_odd;
        end
      end else if (active_video_in) begin
        col_odd <= ~col_odd;
      end
    end
  end

  // Site of the incoming sample after phase offset
  wire [1:0] site_in;
  assign site_in = {row_odd ^ work_phase[`BPV_PHASE_ROW_BIT],
                    col_odd ^ work_phase[`BPV_PHASE_COL_BIT]};

  ////////////////////////////////////////////////////////////////////////
  // Blanking and valid delay lines

  // delay line keeps blanking in step with data
  reg [DS-1:0] hb_line;
  reg [DS-1:0] vb_line;
  reg [DS-1:0] av_line;

  // no synchronous clear on the delay lines
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      hb_line <= {DS{1'b0}};
      vb_line <= {DS{1'b0}};
      av_line <= {DS{1'b0}};
    end else if (adv) begin
      hb_line <= {hb_line[DS-2:0], hblank_in};
      vb_line <= {vb_line[DS-2:0], vblank_in};
      av_line <= {av_line[DS-2:0], active_video_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Datapath stages 1 to 6

  reg [1:0] s1_site;
  reg [IW-1:0] hold_r;
  reg [IW-1:0] hold_g;
  reg [IW-1:0] hold_b;
  reg [IW-1:0] s2_grey;
  reg [BW-1:0] s3_rgb;
  reg [BW-1:0] s4_rgb;
  reg [BW-1:0] s5_rgb;
  reg [BW-1:0] s6_rgb;
  reg [IW-1:0] next_r;
  reg [IW-1:0] next_g;
  reg [IW-1:0] next_b;

  // Black level subtraction with floor at zero
  function [OW-1:0] bpv_sub_black;
    input [IW-1:0] val;
    input [IW-1:0] blk;
    begin
      if (val > blk) begin
        bpv_sub_black = val - blk;
      end else begin
        bpv_sub_black = {OW{1'b0}};
      end
    end
  endfunction

  // clear wins over enable on datapath registers
  // clear acts even with enable low
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      s1_data <= {IW{1'b0}};
      s1_site <= 2'h0;
      hold_r <= {IW{1'b0}};
      hold_g <= {IW{1'b0}};
      hold_b <= {IW{1'b0}};
      s2_grey <= {IW{1'b0}};
      s3_rgb <= {BW{1'b0}};
      s4_rgb <= {BW{1'b0}};
      s5_rgb <= {BW{1'b0}};
      s6_rgb <= {BW{1'b0}};
    end else if (sclr_in) begin
      s1_data <= {IW{1'b0}};
      s1_site <= 2'h0;
      hold_r <= {IW{1'b0}};
      hold_g <= {IW{1'b0}};
      hold_b <= {IW{1'b0}};
      s2_grey <= {IW{1'b0}};
      s3_rgb <= {BW{1'b0}};
      s4_rgb <= {BW{1'b0}};
      s5_rgb <= {BW{1'b0}};
      s6_rgb <= {BW{1'b0}};
    end else if (adv) begin
      s1_data <= video_data_in;
      s1_site <= site_in;
      hold_r <= next_r;
      hold_g <= next_g;
      hold_b <= next_b;
      s2_grey <= s1_data;
      // red high, blue middle, green low
      if (work_ctrl[`BPV_CTRL_ENABLE_BIT]) begin
        s3_rgb <= {hold_r, hold_b, hold_g};
      end else begin
        s3_rgb <= {s2_grey, s2_grey, s2_grey};
      end
      s4_rgb[`BPV_RED_MSB:`BPV_RED_LSB] <=
        bpv_sub_black(s3_rgb[`BPV_RED_MSB:`BPV_RED_LSB], work_black);
      s4_rgb[`BPV_BLUE_MSB:`BPV_BLUE_LSB] <=
        bpv_sub_black(s3_rgb[`BPV_BLUE_MSB:`BPV_BLUE_LSB], work_black);
      s4_rgb[`BPV_GREEN_MSB:`BPV_GREEN_LSB] <=
        bpv_sub_black(s3_rgb[`BPV_GREEN_MSB:`BPV_GREEN_LSB], work_black);
      s5_rgb <= s4_rgb;
      s6_rgb <= s5_rgb;
    end
  end

  // Latest sample of each colour, held across the line
  always @* begin
    next_r = hold_r;
    next_g = hold_g;
    next_b = hold_b;
    if (av_line[0]) begin
      case (s1_site)
        `BPV_SITE_RED: next_r = s1_data;
        `BPV_SITE_GREEN_A: next_g = s1_data;
        `BPV_SITE_GREEN_B: next_g = s1_data;
        `BPV_SITE_BLUE: next_b = s1_data;
        default: next_g = s1_data;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-entry output buffer

  reg [BW-1:0] skid_data;
  reg skid_hb;
  reg skid_vb;
  reg skid_av;
  reg skid_valid;
  wire drain;
  wire push;
  assign drain = ~stream_valid_out | sink_ready_in;
  assign push = adv;

  // valid travels with data, never gates it
  // seventh stage is the output register
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      video_data_out <= {BW{1'b0}};
      hblank_out <= 1'b0;
      vblank_out <= 1'b0;
      active_video_out <= 1'b0;
      stream_valid_out <= 1'b0;
      skid_data <= {BW{1'b0}};
      skid_hb <= 1'b0;
      skid_vb <= 1'b0;
      skid_av <= 1'b0;
      skid_valid <= 1'b0;
      in_ready_out <= 1'b1;
    end else if (sclr_in) begin
      video_data_out <= {BW{1'b0}};
      stream_valid_out <= 1'b0;
      skid_data <= {BW{1'b0}};
      skid_valid <= 1'b0;
      in_ready_out <= 1'b1;
    end else if (ce_in) begin
      if (drain) begin
        if (skid_valid) begin
          video_data_out <= skid_data;
          hblank_out <= skid_hb;
          vblank_out <= skid_vb;
          active_video_out <= skid_av;
          stream_valid_out <= 1'b1;
          skid_valid <= 1'b0;
          in_ready_out <= 1'b1;
        end else if (push) begin
          video_data_out <= s6_rgb;
          hblank_out <= hb_line[DS-1];
          vblank_out <= vb_line[DS-1];
          active_video_out <= av_line[DS-1];
          stream_valid_out <= 1'b1;
        end else begin
          stream_valid_out <= 1'b0;
        end
      end else if (push) begin
        skid_data <= s6_rgb;
        skid_hb <= hb_line[DS-1];
        skid_vb <= vb_line[DS-1];
        skid_av <= av_line[DS-1];
        skid_valid <= 1'b1;
        in_ready_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event status and interrupt request

  reg [`BPV_STAT_WIDTH-1:0] event_now;
  reg [`BPV_STAT_WIDTH-1:0] next_status;

  // Frame end and valid data during frame blanking
  always @* begin
    event_now = {`BPV_STAT_WIDTH{1'b0}};
    if (adv) begin
      event_now[`BPV_STAT_FRAME_END_BIT] = frame_end;
      event_now[`BPV_STAT_TIMING_ERR_BIT] = vblank_in & active_video_in;
    end
    next_status = (status_out & ~status_clear_in) | event_now;
  end

  // sticky events gated onto one request line
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      status_out <= {`BPV_STAT_WIDTH{1'b0}};
      irq_out <= 1'b0;
    end else if (sclr_in) begin
      status_out <= {`BPV_STAT_WIDTH{1'b0}};
      irq_out <= 1'b0;
    end else if (ce_in) begin
      status_out <= next_status;
      irq_out <= |(next_status & irq_mask_in);
    end
  end

endmodule

//--- bpv_consts.vh
// Constants shared by the Bayer pipeline video port
`ifndef BPV_CONSTS_VH
`define BPV_CONSTS_VH

// Sample and component widths
`define BPV_INPUT_SAMPLE_WIDTH 8
`define BPV_OUTPUT_COMPONENT_WIDTH 8
`define BPV_OUT_BUS_WIDTH 24

// Output bus field positions
`define BPV_RED_MSB 23
`define BPV_RED_LSB 16
`define BPV_BLUE_MSB 15
`define BPV_BLUE_LSB 8
`define BPV_GREEN_MSB 7
`define BPV_GREEN_LSB 0

// Processing latency in clock enables
`define BPV_LATENCY 7
`define BPV_DELAY_STAGES 6

// Control word bits
`define BPV_CTRL_ENABLE_BIT 0
`define BPV_CTRL_DONE_BIT 1

// Bayer phase bits
`define BPV_PHASE_COL_BIT 0
`define BPV_PHASE_ROW_BIT 1

// Colour site codes
`define BPV_SITE_RED 2'h0
`define BPV_SITE_GREEN_A 2'h1
`define BPV_SITE_GREEN_B 2'h2
`define BPV_SITE_BLUE 2'h3

// Status and mask bits
`define BPV_STAT_FRAME_END_BIT 0
`define BPV_STAT_TIMING_ERR_BIT 1
`define BPV_STAT_WIDTH 2

// Reset values of working registers
`define BPV_CTRL_RESET 2'h1
`define BPV_PHASE_RESET 2'h0
`define BPV_BLACK_RESET 8'h00

`endif

//--- bpv_port_monitor.sv
// Concurrent checks on the video port pins
`timescale 1ns/1ps
`include "bpv_consts.vh"
module bpv_port_monitor (
  // Clock, reset, enable, clear
  input wire clk_sys_in,
  input wire reset_in,
  input wire ce_in,
  input wire sclr_in,
  // Streams
  input wire hblank_in,
  input wire vblank_in,
  input wire active_video_in,
  input wire in_ready_out,
  input wire [`BPV_OUT_BUS_WIDTH-1:0] video_data_out,
  input wire hblank_out,
  input wire vblank_out,
  input wire active_video_out,
  input wire stream_valid_out,
  input wire sink_ready_in,
  // Status
  input wire [`BPV_STAT_WIDTH-1:0] irq_mask_in,
  input wire [`BPV_STAT_WIDTH-1:0] status_out,
  input wire irq_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // One edge of unstalled flow, reset already sampled low
  sequence s_flow;
    !reset_in && ce_in && !sclr_in && in_ready_out && sink_ready_in;
  endsequence
  // Seven edges of flow fill the pipeline
  sequence s_fill;
    s_flow [*7];
  endsequence
  a_blank_delay: assert property (
    s_fill |=> {hblank_out, vblank_out, active_video_out} ==
      $past({hblank_in, vblank_in, active_video_in}, 7))
    else $error("blanking out of step");
  a_valid_fill: assert property (
    s_fill |=> stream_valid_out)
    else $error("no valid word after latency");
  a_hold_stall: assert property (
    stream_valid_out && !sink_ready_in && !sclr_in
      |=> stream_valid_out && $stable(video_data_out))
    else $error("word lost while stalled");
  a_ce_freeze: assert property (
    !ce_in && !sclr_in |=> $stable({video_data_out, hblank_out,
      vblank_out, active_video_out, stream_valid_out, status_out}))
    else $error("outputs moved with enable low");
  a_clear_zero: assert property (
    sclr_in |=> video_data_out == 0 && !stream_valid_out &&
      status_out == 0 && !irq_out)
    else $error("clear left outputs set");
  a_clear_no_ce: assert property (
    sclr_in && !ce_in |=> in_ready_out && !stream_valid_out)
    else $error("clear ignored with enable low");
  a_irq_masked: assert property (
    ce_in && irq_mask_in == 0 |=> !irq_out)
    else $error("interrupt raised while masked");
  a_ready_back: assert property (
    (ce_in && sink_ready_in && !sclr_in) [*2] |=> in_ready_out)
    else $error("input ready not restored");
endmodule

bind bpv_video_port bpv_port_monitor bpv_port_monitor_inst (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(ce_in),
  .sclr_in(sclr_in), .hblank_in(hblank_in), .vblank_in(vblank_in),
  .active_video_in(active_video_in), .in_ready_out(in_ready_out),
  .video_data_out(video_data_out), .hblank_out(hblank_out),
  .vblank_out(vblank_out), .active_video_out(active_video_out),
  .stream_valid_out(stream_valid_out), .sink_ready_in(sink_ready_in),
  .irq_mask_in(irq_mask_in), .status_out(status_out), .irq_out(irq_out)
);

//--- bpv_sink_model.sv
// Downstream sink that accepts or stalls output words
`timescale 1ns/1ps
module bpv_sink_model (
  // Clock and reset
  input wire clk_sys_in,
  input wire reset_in,
  // Stall request from the bench
  input wire stall_en_in,
  // Handshake to the port
  output reg sink_ready_out
);
  integer seed = 32'h1b7;
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in)
      sink_ready_out <= 1'b1;
    else
      sink_ready_out <= !stall_en_in || (($random(seed) & 3) == 0);
  end
endmodule

//--- bpv_video_port_test.sv
// Self-checking bench for the Bayer pipeline video port
`timescale 1ns/1ps
`include "bpv_consts.vh"
module bpv_video_port_test;
  reg clk_sys_in = 1'b0, reset_in = 1'b1, ce_in = 1'b1, sclr_in = 1'b0;
  reg hblank_in = 1'b1, vblank_in = 1'b0, active_video_in = 1'b0;
  reg [7:0] video_data_in = 8'h00, black_level_in = 8'h00;
  reg [1:0] control_in = 2'h1, bayer_phase_in = 2'h0;
  reg [1:0] irq_mask_in = 2'h0, status_clear_in = 2'h0;
  reg stall_en = 1'b0, ce_rand = 1'b0;
  wire in_ready_out, hblank_out, vblank_out, active_video_out;
  wire stream_valid_out, sink_ready_in, irq_out;
  wire [`BPV_OUT_BUS_WIDTH-1:0] video_data_out;
  wire [1:0] status_out;
  integer seed = 32'h34e2, failures = 0, num_checks = 0, t;
  reg [23:0] exp_q [$];

  bpv_video_port bpv_video_port_inst (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .ce_in(ce_in),
    .sclr_in(sclr_in), .video_data_in(video_data_in),
    .hblank_in(hblank_in), .vblank_in(vblank_in),
    .active_video_in(active_video_in), .in_ready_out(in_ready_out),
    .video_data_out(video_data_out), .hblank_out(hblank_out),
    .vblank_out(vblank_out), .active_video_out(active_video_out),
    .stream_valid_out(stream_valid_out), .sink_ready_in(sink_ready_in),
    .control_in(control_in), .bayer_phase_in(bayer_phase_in),
    .black_level_in(black_level_in), .irq_mask_in(irq_mask_in),
    .status_clear_in(status_clear_in), .status_out(status_out),
    .irq_out(irq_out));
  bpv_sink_model bpv_sink_model_inst (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .stall_en_in(stall_en),
    .sink_ready_out(sink_ready_in));

  always #4 clk_sys_in = ~clk_sys_in;

  task results;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task check(input [23:0] exp, input [23:0] got, input [8*10-1:0] name);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // Bench copy of working set, scan position and colour holds
  reg [1:0] m_ctrl = 2'h1, m_ph = 2'h0, m_site = 2'h0;
  reg [7:0] m_blk = 8'h00, m_r = 8'h00, m_g = 8'h00, m_b = 8'h00;
  reg m_vbp = 1'b0, m_avp = 1'b0, m_col = 1'b0, m_row = 1'b0;
  reg m_le = 1'b0;

  // Component with black level removed, floor zero
  function [7:0] floor_sub(input [7:0] s, input [7:0] b);
    begin
      floor_sub = (s > b) ? s - b : 8'h00;
    end
  endfunction

  task send(input integer n, input hb);
    integer k;
    begin
      k = 0;
      t = 0;
      while (k < n) begin
        @(posedge clk_sys_in);
        t = t + 1;
        if (t > 4000) begin
          check(24'h0, 24'h1, "timeout");
          results;
        end
        if (ce_in && in_ready_out) begin
          k = k + 1;
          video_data_in <= $random(seed);
          active_video_in <= !hb && k < n;
          hblank_in <= hb || k == n;
        end
        ce_in <= !ce_rand || (($random(seed) & 3) != 0);
      end
    end
  endtask

  // Frame blanking interval
  task frame;
    begin
      // Flush active words before the working set changes
      send(8, 1'b1);
      vblank_in <= 1'b1;
      send(8, 1'b1);
      vblank_in <= 1'b0;
    end
  endtask

  // Scoreboard on taken input and output words
  always @(posedge clk_sys_in) begin
    if (!reset_in && sclr_in) begin
      {m_r, m_g, m_b} = 24'h0;
      {m_vbp, m_avp, m_col, m_row} = 4'h0;
    end else if (!reset_in && ce_in) begin
      if (stream_valid_out && sink_ready_in && active_video_out) begin
        if (exp_q.size() == 0)
          check(24'h1, 24'h0, "extra");
        else
          check(exp_q.pop_front(), video_data_out, "data");
      end
      if (in_ready_out) begin
        m_site = {m_row ^ m_ph[1], m_col ^ m_ph[0]};
        m_le = m_avp && !active_video_in;
        if (active_video_in) begin
          case (m_site)
            `BPV_SITE_RED: m_r = video_data_in;
            `BPV_SITE_BLUE: m_b = video_data_in;
            default: m_g = video_data_in;
          endcase
          if (m_ctrl[0])
            exp_q.push_back({floor_sub(m_r, m_blk), floor_sub(m_b, m_blk),
                             floor_sub(m_g, m_blk)});
          else
            exp_q.push_back({3{floor_sub(video_data_in, m_blk)}});
        end
        if (vblank_in) begin
          {m_row, m_col} = 2'h0;
        end else if (m_le || hblank_in) begin
          m_col = 1'b0;
          m_row = m_row ^ m_le;
        end else if (active_video_in) begin
          m_col = !m_col;
        end
        if (vblank_in && !m_vbp && control_in[1]) begin
          m_ctrl = control_in;
          m_ph = bayer_phase_in;
          m_blk = black_level_in;
        end
        m_vbp = vblank_in;
        m_avp = active_video_in;
      end
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(posedge clk_sys_in);
    check(24'h4, {21'h0, in_ready_out, stream_valid_out, irq_out}, "rst");
    send(40, 1'b0);
    control_in <= 2'h2;
    frame;
    send(40, 1'b0);
    control_in <= 2'h0;
    black_level_in <= 8'h30;
    frame;
    send(40, 1'b0);
    control_in <= 2'h2;
    frame;
    stall_en <= 1'b1;
    ce_rand = 1'b1;
    send(80, 1'b0);
    stall_en <= 1'b0;
    ce_rand = 1'b0;
    send(20, 1'b0);
    @(posedge clk_sys_in);
    sclr_in <= 1'b1;
    ce_in <= 1'b0;
    @(posedge clk_sys_in);
    ce_in <= 1'b1;
    @(posedge clk_sys_in);
    check(24'h0, video_data_out, "clr_data");
    repeat (6) @(posedge clk_sys_in);
    sclr_in <= 1'b0;
    exp_q.delete();
    control_in <= 2'h3;
    bayer_phase_in <= 2'h1;
    frame;
    send(30, 1'b0);
    send(30, 1'b0);
    status_clear_in <= 2'h3;
    repeat (3) @(posedge clk_sys_in);
    status_clear_in <= 2'h0;
    irq_mask_in <= 2'h1;
    check(24'h0, {22'h0, status_out}, "status");
    frame;
    t = 0;
    while (irq_out !== 1'b1 && t < 20) begin
      @(posedge clk_sys_in);
      t = t + 1;
    end
    check(24'h1, {23'h0, irq_out}, "irq");
    irq_mask_in <= 2'h0;
    send(12, 1'b1);
    check(24'h0, {23'h0, irq_out}, "irq_mask");
    vblank_in <= 1'b1;
    send(2, 1'b0);
    vblank_in <= 1'b0;
    send(12, 1'b1);
    check(24'h2, {22'h0, status_out & 2'h2}, "stat_err");
    check(24'h0, 24'(exp_q.size()), "left");
    results;
  end
endmodule
